// *** chan_start_regs.vh ***
// constants for the descriptor start and credit block
// Notes on behaviour
// - 64-bit start pointer from high/low registers
// - first fetch at start pointer on run rise
// - six-bit adjacent count, fetched with start
// - credit write adds to outstanding count
// - credits limit fetches only in credit mode
// - credits cleared on run falling edge
// - credits cleared while credit mode off
// - credit read returns remaining credits
// - identity bit 15 reports streaming interface
// - identity bits 11:8 channel index, 14:12 zero
// - mode bits 0 and 16 enable crediting
// - in credit mode, never fetch beyond granted credits
`ifndef CHAN_START_REGS_VH
`define CHAN_START_REGS_VH
`define OFF_IDENT 8'h00
`define OFF_PTR_LO 8'h80
`define OFF_PTR_HI 8'h84
`define OFF_ADJ 8'h88
`define OFF_CRED 8'h8c
`define OFF_RUN 8'hc0
`define OFF_MODE 8'hc4
`define OFF_STATUS 8'hc8
`define ADJ_W 6
`define CRED_W 10
`define CRED_ZERO 10'h000
`define ID_STREAM_BIT 15
`define ID_CHAN_LSB 8
`define MODE_CARD_TO_HOST_LSB 16
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// *** chan_credit.v ***
// one channel: start pointer, adjacent count, credit counter and fetch issue
`timescale 1ns/100ps
`include "chan_start_regs.vh"
module chan_credit (
	input wire aclk,
	input wire aresetn,
	input wire wr_lo,
	input wire wr_hi,
	input wire wr_adj,
	input wire wr_cred,
	input wire [31:0] wdata,
	input wire run,
	input wire credit_mode_on,
	input wire fetch_ready,
	input wire fetch_done,
	output reg [31:0] ptr_lo_r,
	output reg [31:0] ptr_hi_r,
	output reg [5:0] adj_r,
	output reg [9:0] credit_r,
	output wire fetch_valid,
	output reg [63:0] fetch_addr_r,
	output reg [5:0] fetch_adj_r,
	output wire busy
);
	reg run_d_r;
	reg pending_r;
	wire run_rise;
	wire run_fall;
	wire take;
	wire allowed;
	wire [10:0] sum;
	reg [9:0] credit_nxt;

	assign run_rise = run & ~run_d_r;
	assign run_fall = ~run & run_d_r;
	assign allowed = ~credit_mode_on | (credit_r != `CRED_ZERO);
	assign fetch_valid = run & pending_r & allowed;
	assign take = fetch_valid & fetch_ready;
	assign busy = pending_r;
	assign sum = {1'b0, credit_r} + {1'b0, wdata[9:0]};

	always @* begin
		credit_nxt = credit_r;
		if (wr_cred) begin
			credit_nxt = sum[10] ? 10'h3ff : sum[9:0];
		end
		if (take && credit_mode_on) begin
			credit_nxt = credit_nxt - 10'h001;
		end
		if (run_fall || !credit_mode_on) begin
			credit_nxt = `CRED_ZERO;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			ptr_lo_r <= 32'h00000000;
			ptr_hi_r <= 32'h00000000;
			adj_r <= 6'h00;
			credit_r <= `CRED_ZERO;
			run_d_r <= 1'b0;
			pending_r <= 1'b0;
			fetch_addr_r <= 64'h0;
			fetch_adj_r <= 6'h00;
		end else begin
			run_d_r <= run;
			credit_r <= credit_nxt;
			if (wr_lo) begin
				ptr_lo_r <= wdata;
			end
			if (wr_hi) begin
				ptr_hi_r <= wdata;
			end
			if (wr_adj) begin
				adj_r <= wdata[5:0];
			end
			if (run_rise) begin
				pending_r <= 1'b1;
				fetch_addr_r <= {ptr_hi_r, ptr_lo_r};
				fetch_adj_r <= adj_r;
			end else if (!run || (pending_r && fetch_done)) begin
				pending_r <= 1'b0;
			end
		end
	end
endmodule // chan_credit

// *** sg_start_credits.v ***
// axi4-lite register block for one host-to-card and one card-to-host channel
`timescale 1ns/100ps
`include "chan_start_regs.vh"
module sg_start_credits #(
	parameter [3:0] host_to_card_index = 4'h0,
	parameter [3:0] card_to_host_index = 4'h0,
	parameter host_to_card_stream = 1'b0,
	parameter card_to_host_stream = 1'b0
) (
	input wire aclk,
	input wire aresetn,
	input wire [11:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [11:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire [1:0] fetch_ready,
	input wire [1:0] fetch_done,
	output wire [1:0] fetch_valid,
	output wire [127:0] fetch_addr,
	output wire [11:0] fetch_adj
);
	////////////////////////////////////////////////////////////////////////
	// write channel: address and data caught in either order
	reg aw_held_r;
	reg w_held_r;
	reg [11:0] awaddr_r;
	reg [31:0] wdata_r;
	reg [3:0] wstrb_r;
	reg [1:0] run_r;
	reg [31:0] mode_r;
	wire do_write;
	wire wsel;
	wire [7:0] woff;
	wire wmapped;

	assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
	assign s_axi_wready = ~w_held_r & ~s_axi_bvalid;
	assign do_write = aw_held_r & w_held_r & ~s_axi_bvalid;
	assign wsel = awaddr_r[8];
	assign woff = awaddr_r[7:0];
	assign wmapped = (awaddr_r[11:9] == 3'h0) && (woff == `OFF_PTR_LO || woff == `OFF_PTR_HI
		|| woff == `OFF_ADJ || woff == `OFF_CRED || woff == `OFF_RUN || woff == `OFF_MODE
		|| woff == `OFF_IDENT || woff == `OFF_STATUS);

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			awaddr_r <= 12'h000;
			wdata_r <= 32'h00000000;
			wstrb_r <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wmapped ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// write strobes, full-word writes only for every register
	wire full = (wstrb_r == 4'hf);
	wire [1:0] wr_lo;
	wire [1:0] wr_hi;
	wire [1:0] wr_adj;
	wire [1:0] wr_cred;
	wire [1:0] busy;
	wire [1:0] mode_on;
	wire [63:0] ptr_lo;
	wire [63:0] ptr_hi;
	wire [11:0] adj;
	wire [19:0] credit;

	assign mode_on = {mode_r[`MODE_CARD_TO_HOST_LSB], mode_r[0]};

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1) begin : chan
			wire hit = do_write & wmapped & full & (wsel == ch);
			assign wr_lo[ch] = hit & (woff == `OFF_PTR_LO);
			assign wr_hi[ch] = hit & (woff == `OFF_PTR_HI);
			assign wr_adj[ch] = hit & (woff == `OFF_ADJ);
			assign wr_cred[ch] = hit & (woff == `OFF_CRED);
			chan_credit u_chan (
				.aclk(aclk),
				.aresetn(aresetn),
				.wr_lo(wr_lo[ch]),
				.wr_hi(wr_hi[ch]),
				.wr_adj(wr_adj[ch]),
				.wr_cred(wr_cred[ch]),
				.wdata(wdata_r),
				.run(run_r[ch]),
				.credit_mode_on(mode_on[ch]),
				.fetch_ready(fetch_ready[ch]),
				.fetch_done(fetch_done[ch]),
				.ptr_lo_r(ptr_lo[ch*32 +: 32]),
				.ptr_hi_r(ptr_hi[ch*32 +: 32]),
				.adj_r(adj[ch*6 +: 6]),
				.credit_r(credit[ch*10 +: 10]),
				.fetch_valid(fetch_valid[ch]),
				.fetch_addr_r(fetch_addr[ch*64 +: 64]),
				.fetch_adj_r(fetch_adj[ch*6 +: 6]),
				.busy(busy[ch])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// run bits and credit mode enables
	always @(posedge aclk) begin
		if (!aresetn) begin
			run_r <= 2'b00;
			mode_r <= 32'h00000000;
		end else if (do_write && wmapped && full) begin
			if (woff == `OFF_RUN) begin
				run_r[wsel] <= wdata_r[0];
			end else if (woff == `OFF_MODE && !wsel) begin
				mode_r <= {12'h000, wdata_r[19:16], 12'h000, wdata_r[3:0]};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read channel, one cycle after the address
	wire rsel = s_axi_araddr[8];
	wire [7:0] roff = s_axi_araddr[7:0];
	wire [3:0] rindex = rsel ? card_to_host_index : host_to_card_index;
	wire rstream = rsel ? card_to_host_stream : host_to_card_stream;
	reg [31:0] rd_nxt;
	reg rerr_nxt;

	assign s_axi_arready = ~s_axi_rvalid;

	always @* begin
		rd_nxt = 32'h00000000;
		rerr_nxt = 1'b0;
		if (s_axi_araddr[11:9] != 3'h0) begin
			rerr_nxt = 1'b1;
		end else if (roff == `OFF_IDENT) begin
			rd_nxt[`ID_STREAM_BIT] = rstream;
			rd_nxt[`ID_CHAN_LSB +: 4] = rindex;
		end else if (roff == `OFF_PTR_LO) begin
			rd_nxt = ptr_lo[rsel*32 +: 32];
		end else if (roff == `OFF_PTR_HI) begin
			rd_nxt = ptr_hi[rsel*32 +: 32];
		end else if (roff == `OFF_ADJ) begin
			rd_nxt[5:0] = adj[rsel*6 +: 6];
		end else if (roff == `OFF_CRED) begin
			rd_nxt[9:0] = credit[rsel*10 +: 10];
		end else if (roff == `OFF_RUN) begin
			rd_nxt[0] = run_r[rsel];
		end else if (roff == `OFF_MODE) begin
			rd_nxt = mode_r;
		end else if (roff == `OFF_STATUS) begin
			rd_nxt[0] = busy[rsel];
			rd_nxt[1] = fetch_valid[rsel];
		end else begin
			rerr_nxt = 1'b1;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_nxt;
			s_axi_rresp <= rerr_nxt ? `RESP_SLVERR : `RESP_OKAY;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule // sg_start_credits

// *** sg_chk_asserts.sv ***
// assertions on the ports of the start and credit block
`timescale 1ns/100ps
module sg_chk #(
	parameter [3:0] host_to_card_index = 4'h0,
	parameter [0:0] host_to_card_stream = 1'b0
) (
	input wire aclk,
	input wire aresetn,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [11:0] s_axi_araddr,
	input wire s_axi_rvalid,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire [1:0] fetch_valid,
	input wire [127:0] fetch_addr,
	input wire [11:0] fetch_adj
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	reg [11:0] ra_r;
	always @(posedge aclk)
		if (s_axi_arvalid && s_axi_arready) ra_r <= s_axi_araddr;
	////////////////////////////////////////////////////////////////
	write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
		s_axi_wready |=> ##1 s_axi_bvalid) else $error("no write response");
	aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("no read response");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read overlap");
	read_unmapped_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[11:9] != 0
		|=> s_axi_rresp == 2'b10 && s_axi_rdata == 0) else $error("unmapped read");
	ident_fields_a: assert property (
		s_axi_rvalid && ra_r == 12'h000 |-> s_axi_rdata == {16'h0, host_to_card_stream, 3'h0,
		host_to_card_index, 8'h0}) else $error("identity fields wrong");
	start_addr_a: assert property (
		fetch_valid[0] && $past(fetch_valid[0]) |-> $stable(fetch_addr[63:0]))
		else $error("fetch address moved");
	adj_hold_a: assert property (
		fetch_valid[1] && $past(fetch_valid[1]) |-> $stable(fetch_adj[11:6]))
		else $error("adjacent count moved");
endmodule // sg_chk
bind sg_start_credits sg_chk #(.host_to_card_index(host_to_card_index),
	.host_to_card_stream(host_to_card_stream)) u_chk (.*);

// *** sg_start_credits_tb.sv ***
// testbench for the start and credit block
`timescale 1ns/100ps
module sg_start_credits_tb;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [11:0] s_axi_awaddr, s_axi_araddr, fetch_adj;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, fetch_ready, fetch_done, fetch_valid;
	logic [127:0] fetch_addr;
	int mismatches, n_tests;
	sg_start_credits #(.host_to_card_index(4'h3), .card_to_host_index(4'ha),
		.card_to_host_stream(1'b1)) u_dut (.*);
	initial begin
		aclk = 0;
		forever #2.5 aclk = ~aclk;
	end
	////////////////////////////////////////////////////////////////
	task chk(string n, logic [63:0] e, logic [63:0] s);
		n_tests++;
		if (s !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task wr(input [11:0] a, input [31:0] v, input [1:0] er);
		bit ta, tw;
		{ta, tw} = 2'h0;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(negedge aclk);
			if (s_axi_awvalid && s_axi_awready) ta = 1;
			if (s_axi_wvalid && s_axi_wready) tw = 1;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 0;
			if (tw) s_axi_wvalid <= 0;
		end while (!(ta && tw));
		do @(negedge aclk); while (!s_axi_bvalid);
		@(posedge aclk);
		s_axi_bready <= 0;
		chk("bresp", er, s_axi_bresp);
		@(posedge aclk);
	endtask
	task rd(input [11:0] a, input [31:0] e, input [1:0] er);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do @(negedge aclk); while (!s_axi_arready);
		@(posedge aclk);
		s_axi_arvalid <= 0;
		do @(negedge aclk); while (!s_axi_rvalid);
		@(posedge aclk);
		s_axi_rready <= 0;
		chk("rdata", e, s_axi_rdata);
		chk("rresp", er, s_axi_rresp);
		@(posedge aclk);
	endtask
	// counts descriptors taken over twelve cycles of ready
	task takes(input int ch, input int n);
		int c;
		c = 0;
		fetch_ready[ch] <= 1;
		repeat (12) begin
			@(negedge aclk);
			if (fetch_valid[ch] && fetch_ready[ch]) c++;
		end
		@(posedge aclk);
		fetch_ready[ch] <= 0;
		chk("takes", n, c);
	endtask
	task t_fetch(input [11:0] b, input int ch);
		wr(b | 12'h080, 32'h89ab_cdef, 0);
		wr(b | 12'h084, 32'h0123_4567, 0);
		wr(b | 12'h088, 32'h3f, 0);
		rd(b | 12'h084, 32'h0123_4567, 0);
		rd(b | 12'h088, 32'h3f, 0);
		wr(b | 12'h0c0, 1, 0);
		do @(negedge aclk); while (!fetch_valid[ch]);
		@(negedge aclk);
		chk("addr", 64'h0123_4567_89ab_cdef, fetch_addr[ch*64 +: 64]);
		chk("adj", 6'h3f, fetch_adj[ch*6 +: 6]);
		@(posedge aclk);
		rd(b | 12'h0c8, 32'h3, 0);
		fetch_done[ch] <= 1;
		@(posedge aclk);
		fetch_done[ch] <= 0;
		@(negedge aclk);
		chk("done", 0, fetch_valid[ch]);
		@(posedge aclk);
		rd(b | 12'h0c8, 0, 0);
		wr(b | 12'h0c0, 0, 0);
	endtask
	task t_credit(input [11:0] b, input int ch);
		wr(12'h0c4, 32'h1 << (ch * 16), 0);
		wr(b | 12'h08c, 2, 0);
		wr(b | 12'h08c, 3, 0);
		rd(b | 12'h08c, 5, 0);
		wr(b | 12'h0c0, 1, 0);
		takes(ch, 5);
		rd(b | 12'h08c, 0, 0);
		wr(b | 12'h08c, 1, 0);
		takes(ch, 1);
		wr(b | 12'h08c, 7, 0);
		wr(b | 12'h0c0, 0, 0);
		rd(b | 12'h08c, 0, 0);
		wr(b | 12'h08c, 4, 0);
		rd(b | 12'h08c, 4, 0);
		wr(12'h0c4, 0, 0);
		rd(b | 12'h08c, 0, 0);
		wr(b | 12'h0c0, 1, 0);
		takes(ch, 12);
		wr(b | 12'h0c0, 0, 0);
	endtask
	task t_map;
		for (int i = 0; i < 8; i++) rd(12'(i / 4 * 256 + 128 + i % 4 * 4), 0, 0);
		rd(12'h000, 32'h0000_0300, 0);
		rd(12'h100, 32'h0000_8a00, 0);
		rd(12'h200, 0, 2'b10);
		wr(12'h400, 1, 2'b10);
		s_axi_wstrb <= 4'h1;
		wr(12'h080, 32'h1, 0);
		s_axi_wstrb <= 4'hf;
		rd(12'h080, 0, 0);
	endtask
	task print_verdict;
		if (mismatches == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, fetch_ready, fetch_done} = 0;
		s_axi_wstrb = 4'hf;
		{mismatches, n_tests} = 0;
		repeat (3) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		t_map;
		for (int ch = 0; ch < 2; ch++) begin
			t_fetch(12'(ch * 256), ch);
			t_credit(12'(ch * 256), ch);
		end
		print_verdict;
	end
	initial begin
		#40000;
		mismatches++;
		print_verdict;
	end
endmodule // sg_start_credits_tb
